/* File: cts_pkg.sv */
/*
 * Shared constants for the charger tuning/status register pair: register
 * offsets, field positions, reset values, indicator codes, timing and the
 * serial slave state type.
 * Assumes a single 50 MHz clock domain.
 */
package cts_pkg;

    localparam logic [7:0] DETECT_STATUS_ADDR = 8'h0E;
    localparam logic [7:0] TUNING_CTRL_ADDR   = 8'h0F;

    localparam int DETECT_DONE_BIT = 7;
    localparam int TRIM_MSB        = 7;
    localparam int TRIM_LSB        = 6;
    localparam int TRICKLE_BIT     = 4;
    localparam int IND_MSB         = 3;
    localparam int IND_LSB         = 2;
    localparam int OFFSET_MSB      = 1;
    localparam int OFFSET_LSB      = 0;

    localparam logic [7:0] TUNING_CTRL_RESET = 8'h00;
    localparam logic       DETECT_DONE_RESET = 1'b0;

    localparam logic [1:0] IND_OFF         = 2'h0;
    localparam logic [1:0] IND_ON          = 2'h1;
    localparam logic [1:0] IND_BLINK_EVEN  = 2'h2;
    localparam logic [1:0] IND_BLINK_LONG  = 2'h3;
    localparam logic [1:0] IND_FUNC_ACTIVE = 2'h1;

    localparam int CLK_HZ            = 50_000_000;
    localparam int BLINK_STEP_MS     = 1000;
    localparam int BLINK_STEP_CYCLES = CLK_HZ / 1000 * BLINK_STEP_MS;

    // value is arbitrary
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2A;

    typedef enum logic [2:0] {
        CTS_IDLE  = 3'b000,
        CTS_ADDR  = 3'b001,
        CTS_ACK   = 3'b010,
        CTS_ACKH  = 3'b011,
        CTS_RXB   = 3'b100,
        CTS_TXB   = 3'b101,
        CTS_TXACK = 3'b110
    } cts_i2c_state_t;

endpackage

/* File: cts_i2c_slave.sv */
/*
 * Two-wire serial slave: address match, register pointer, write with
 * auto-increment, read with auto-increment.
 * Assumes scl/sda already synchronous to clk; sda is open-drain, driven
 * low while sda_oe is high.
 */
`timescale 1ns/1ps
module cts_i2c_slave
    import cts_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe,
    output logic            wr_pulse,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);
    cts_i2c_state_t state_reg;
    logic           scl_prev_reg;
    logic           sda_prev_reg;
    logic [7:0]     shift_reg;
    logic [2:0]     bit_reg;
    logic           rw_reg;
    logic           have_ptr_reg;
    logic [7:0]     ptr_reg;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_seen;
    logic           stop_seen;
    logic [7:0]     byte_in;

    assign scl_rise   = scl_in & ~scl_prev_reg;
    assign scl_fall   = ~scl_in & scl_prev_reg;
    assign start_seen = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
    assign stop_seen  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
    assign byte_in    = {shift_reg[6:0], sda_in};
    assign rd_addr    = ptr_reg;

    // history resets to the idle bus level so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_in;
            sda_prev_reg <= sda_in;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= CTS_IDLE;
            shift_reg    <= 8'h00;
            bit_reg      <= 3'h0;
            rw_reg       <= 1'b0;
            have_ptr_reg <= 1'b0;
            ptr_reg      <= 8'h00;
            sda_oe       <= 1'b0;
            wr_pulse     <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 8'h00;
        end else begin
            wr_pulse <= 1'b0;
            if (start_seen) begin
                state_reg    <= CTS_ADDR;
                bit_reg      <= 3'h0;
                have_ptr_reg <= 1'b0;
                sda_oe       <= 1'b0;
            end else if (stop_seen) begin
                state_reg <= CTS_IDLE;
                sda_oe    <= 1'b0;
            end else begin
                case (state_reg)
                    CTS_ADDR, CTS_RXB: begin
                        if (scl_rise) begin
                            shift_reg <= byte_in;
                            bit_reg   <= bit_reg + 3'h1;
                            if (bit_reg == 3'h7) begin
                                if (state_reg == CTS_ADDR) begin
                                    rw_reg    <= sda_in;
                                    state_reg <= (shift_reg[6:0] == SLAVE_ADDR) ? CTS_ACK
                                                                                : CTS_IDLE;
                                end else begin
                                    state_reg <= CTS_ACK;
                                    if (!have_ptr_reg) begin
                                        ptr_reg      <= byte_in;
                                        have_ptr_reg <= 1'b1;
                                    end else begin
                                        wr_pulse <= 1'b1;
                                        wr_addr  <= ptr_reg;
                                        wr_data  <= byte_in;
                                        ptr_reg  <= ptr_reg + 8'h01;
                                    end
                                end
                            end
                        end
                    end
                    CTS_ACK: begin
                        if (scl_fall) begin
                            sda_oe    <= 1'b1;
                            state_reg <= CTS_ACKH;
                        end
                    end
                    CTS_ACKH: begin
                        if (scl_fall) begin
                            bit_reg <= 3'h0;
                            if (rw_reg) begin
                                shift_reg <= rd_data;
                                sda_oe    <= ~rd_data[7];
                                state_reg <= CTS_TXB;
                            end else begin
                                sda_oe    <= 1'b0;
                                state_reg <= CTS_RXB;
                            end
                        end
                    end
                    CTS_TXB: begin
                        if (scl_fall) begin
                            bit_reg   <= bit_reg + 3'h1;
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            if (bit_reg == 3'h7) begin
                                sda_oe    <= 1'b0;
                                state_reg <= CTS_TXACK;
                            end else begin
                                sda_oe <= ~shift_reg[6];
                            end
                        end
                    end
                    CTS_TXACK: begin
                        if (scl_rise) begin
                            if (sda_in) begin
                                state_reg <= CTS_IDLE;
                            end else begin
                                ptr_reg   <= ptr_reg + 8'h01;
                                state_reg <= CTS_ACKH;
                            end
                        end
                    end
                    default: begin
                        state_reg <= CTS_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* File: cts_regs.sv */
/*
 * Charger tuning and detection status registers behind the two-wire serial
 * port, with the charge indicator pin driver and its blink timer.
 * Assumes all inputs synchronous to clk; event inputs are one-cycle pulses
 * from the detection, reset-command and watchdog logic elsewhere.
 */
// What this block does
// R1: the detection-status flag in bit 7 is set when input-source detection completes.
// R2: bits 6 to 0 of the detection-status register are reserved, read as zero, ignore writes.
// R3: the trim field in bits 7:6 selects no change, plus 8 mV, minus 8 mV or minus 16 mV.
// R4: bit 4 selects trickle current, 0 for 90 mA and 1 for 30 mA.
// R5: bits 3:2 set the indicator pin to off, low, 1 s on 1 s off, or 1 s on 3 s off.
// R6: the indicator field acts only while the indicator function select holds 01.
// R7: bits 1:0 select the input-limit offset of 3.9 V, 5.9 V, 7.5 V or 10.5 V.
// R8: the settings register powers up zero, clears on reset command or watchdog, offset only on reset command.
`timescale 1ns/1ps
module cts_regs
    import cts_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR  = SLAVE_ADDR_DEFAULT,
    parameter int         STEP_CYCLES = BLINK_STEP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       detection_start,
    input  wire logic       source_detect_complete,
    input  wire logic       register_reset_cmd,
    input  wire logic       watchdog_expired,
    input  wire logic [1:0] indicator_function_select,
    output logic [1:0]      charge_voltage_trim,
    output logic            trickle_current_select,
    output logic [1:0]      input_limit_offset,
    output logic            indicator_out,
    output logic            indicator_oe
);
    if (STEP_CYCLES < 2) begin : g_step_check
        $error("STEP_CYCLES must be at least 2");
    end

    logic        detect_done_reg;
    logic [7:0]  ctrl_reg;
    logic        wr_pulse;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_addr;
    logic [7:0]  rd_data;
    logic        slave_oe;
    logic [31:0] step_reg;
    logic [1:0]  phase_reg;
    logic [1:0]  ind_mode;
    logic        ind_lit;

    cts_i2c_slave #(
        .SLAVE_ADDR (SLAVE_ADDR)
    ) u_slave (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe   (slave_oe),
        .wr_pulse (wr_pulse),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data)
    );

    // open-drain data line: the level driven is always low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end
    assign sda_oe = slave_oe;

    // a new detection run clears the flag; completion in the same cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detect_done_reg <= DETECT_DONE_RESET;
        end else if (source_detect_complete) begin
            detect_done_reg <= 1'b1; // R1
        end else if (detection_start) begin
            detect_done_reg <= 1'b0;
        end
    end

    // reset sources override a write landing in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= TUNING_CTRL_RESET; // R8
        end else if (register_reset_cmd) begin
            ctrl_reg <= TUNING_CTRL_RESET; // R8
        end else if (watchdog_expired) begin
            ctrl_reg[7:2] <= TUNING_CTRL_RESET[7:2]; // R8
        end else if (wr_pulse && wr_addr == TUNING_CTRL_ADDR) begin
            ctrl_reg <= wr_data;
        end
    end

    // status register low bits read zero; writes to it are dropped above
    always_comb begin
        rd_data = 8'h00;
        case (rd_addr)
            DETECT_STATUS_ADDR: rd_data = {detect_done_reg, 7'h00}; // R2
            TUNING_CTRL_ADDR:   rd_data = ctrl_reg;
            default:            rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_voltage_trim    <= TUNING_CTRL_RESET[TRIM_MSB:TRIM_LSB];
            trickle_current_select <= TUNING_CTRL_RESET[TRICKLE_BIT];
            input_limit_offset     <= TUNING_CTRL_RESET[OFFSET_MSB:OFFSET_LSB];
        end else begin
            charge_voltage_trim    <= ctrl_reg[TRIM_MSB:TRIM_LSB]; // R3
            trickle_current_select <= ctrl_reg[TRICKLE_BIT]; // R4
            input_limit_offset     <= ctrl_reg[OFFSET_MSB:OFFSET_LSB]; // R7
        end
    end

    assign ind_mode = ctrl_reg[IND_MSB:IND_LSB];

    // one-second step timer; held in reset outside blink modes so a blink entered
    // from off or on opens with a full on second; a switch between blink modes keeps the phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_reg  <= 32'h0000_0000;
            phase_reg <= 2'h0;
        end else if (ind_mode == IND_OFF || ind_mode == IND_ON) begin
            step_reg  <= 32'h0000_0000;
            phase_reg <= 2'h0;
        end else if (step_reg == 32'(STEP_CYCLES - 1)) begin
            step_reg  <= 32'h0000_0000;
            phase_reg <= phase_reg + 2'h1;
        end else begin
            step_reg <= step_reg + 32'h0000_0001;
        end
    end

    always_comb begin
        case (ind_mode)
            IND_ON:         ind_lit = 1'b1; // R5
            IND_BLINK_EVEN: ind_lit = ~phase_reg[0]; // R5
            IND_BLINK_LONG: ind_lit = (phase_reg == 2'h0); // R5
            default:        ind_lit = 1'b0;
        endcase
    end

    // outside the active function select the pin is released
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            indicator_out <= 1'b0;
            indicator_oe  <= 1'b0;
        end else begin
            indicator_out <= 1'b0;
            indicator_oe  <= ind_lit && (indicator_function_select == IND_FUNC_ACTIVE); // R6
        end
    end

    detect_set_a: assert property ( // R1
        @(posedge clk) disable iff (!rst_n)
        source_detect_complete |=> detect_done_reg ##0 rd_data[7] || rd_addr != DETECT_STATUS_ADDR)
        else $error("detection flag not set after completion");

    reserved_zero_a: assert property ( // R2
        @(posedge clk) disable iff (!rst_n)
        rd_addr == DETECT_STATUS_ADDR |-> rd_data[6:0] == 7'h00 && rd_data[7] == detect_done_reg)
        else $error("status reserved bits not zero");

    trim_output_a: assert property ( // R3
        @(posedge clk) disable iff (!rst_n)
        wr_pulse && wr_addr == TUNING_CTRL_ADDR && !register_reset_cmd && !watchdog_expired
        |=> ##1 charge_voltage_trim == $past(wr_data[7:6], 2))
        else $error("trim output does not follow write");

    trickle_output_a: assert property ( // R4
        @(posedge clk) disable iff (!rst_n)
        ##1 trickle_current_select == $past(ctrl_reg[4]))
        else $error("trickle select output mismatch");

    led_steady_a: assert property ( // R5
        @(posedge clk) disable iff (!rst_n)
        (ind_mode == IND_ON && indicator_function_select == 2'h1) [*2] |-> indicator_oe)
        else $error("indicator not held low in on mode");

    led_gate_a: assert property ( // R6
        @(posedge clk) disable iff (!rst_n)
        indicator_function_select != 2'h1 |=> !indicator_oe)
        else $error("indicator driven while function not selected");

    offset_output_a: assert property ( // R7
        @(posedge clk) disable iff (!rst_n)
        ##1 input_limit_offset == $past(ctrl_reg[1:0]))
        else $error("offset output mismatch");

    wdog_keeps_a: assert property ( // R8
        @(posedge clk) disable iff (!rst_n)
        watchdog_expired && !register_reset_cmd
        |=> ctrl_reg[7:2] == 6'h00 && ctrl_reg[1:0] == $past(ctrl_reg[1:0]))
        else $error("watchdog clear wrong");

    regrst_clear_a: assert property ( // R8
        @(posedge clk) disable iff (!rst_n)
        register_reset_cmd |=> ctrl_reg == 8'h00 ##1 input_limit_offset == 2'h0)
        else $error("reset command did not clear settings");

    detect_clear_a: assert property ( // R1
        @(posedge clk) disable iff (!rst_n)
        detection_start && !source_detect_complete |=> !detect_done_reg)
        else $error("detection flag not cleared by a new run");

    status_ro_a: assert property ( // R2
        @(posedge clk) disable iff (!rst_n)
        wr_pulse && wr_addr == DETECT_STATUS_ADDR && !source_detect_complete && !detection_start
        |=> detect_done_reg == $past(detect_done_reg))
        else $error("status register changed by a write");

    blink_long_a: assert property ( // R5
        @(posedge clk) disable iff (!rst_n)
        ind_mode == IND_BLINK_LONG && phase_reg != 2'h0 |=> !indicator_oe)
        else $error("indicator lit in a dark step of the long blink");

    blink_step_a: assert property ( // R5
        @(posedge clk) disable iff (!rst_n)
        ind_mode == IND_BLINK_EVEN && step_reg != 32'(STEP_CYCLES - 1)
        |=> phase_reg == $past(phase_reg))
        else $error("blink step ended early");

    blink_on_a: assert property ( // R5
        @(posedge clk) disable iff (!rst_n)
        ind_mode != IND_OFF && ind_mode != IND_ON && phase_reg == 2'h0
        && indicator_function_select == IND_FUNC_ACTIVE |=> indicator_oe)
        else $error("indicator dark in the opening blink step");
endmodule

/* File: cts_host.sv */
/*
 * Host processor model on the two-wire serial bus: start, stop, byte
 * write with pointer and single-byte read through a repeated start.
 * Assumes an external pull-up that resolves sda from all parties' pull-lows.
 */
`timescale 1ns/1ps
module cts_host
    import cts_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // each scl phase lasts at least four clocks, above the three-clock minimum
    localparam int PHASE = 4;

    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick();
        repeat (PHASE) @(negedge clk);
    endtask

    task automatic start_c();
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask

    task automatic stop_c();
        sda_low = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b0;
        tick();
    endtask

    // sda is held one clock past the scl fall so the slave never sees it move while high
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        tick();
        scl = 1'b1;
        tick();
        r   = sda_line;
        scl = 1'b0;
        @(negedge clk);
    endtask

    task automatic byte_tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        start_c();
        byte_tx({SLAVE_ADDR_DEFAULT, 1'b0});
        byte_tx(ptr);
        byte_tx(d);
        stop_c();
    endtask

    // single byte read, ended by a host not-acknowledge
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        logic r;
        start_c();
        byte_tx({SLAVE_ADDR_DEFAULT, 1'b0});
        byte_tx(ptr);
        start_c();
        byte_tx({SLAVE_ADDR_DEFAULT, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, r);
        stop_c();
    endtask
endmodule

/* File: testbench.sv */
/*
 * Self-checking bench for the charger tuning/status registers: register
 * access through the host model, detection events, indicator modes.
 * Assumes the blink step is shortened to 8 clocks for simulation.
 */
`timescale 1ns/1ps
module testbench;
    import cts_pkg::*;
    localparam int STEP = 8;
    logic       clk;
    logic       rst_n;
    logic       scl;
    logic       host_low;
    logic       sda_w;
    logic       sda_out;
    logic       sda_oe;
    logic [3:0] ev;
    logic [1:0] fsel;
    logic [1:0] trim;
    logic [1:0] offs;
    logic       trickle;
    logic       ind_out;
    logic       ind_oe;
    logic [7:0] rv;
    logic [7:0] wv;
    int         num_errors;
    int         samples_checked;
    int         k;
    int         hi;
    int         ind_exp [4] = '{0, 64, 32, 16};

    // open-drain data line with pull-up
    assign sda_w = ~(host_low | sda_oe);

    cts_regs #(.STEP_CYCLES(STEP)) u_cts_regs (
        .clk                       (clk),
        .rst_n                     (rst_n),
        .scl_in                    (scl),
        .sda_in                    (sda_w),
        .sda_out                   (sda_out),
        .sda_oe                    (sda_oe),
        .detection_start           (ev[0]),
        .source_detect_complete    (ev[1]),
        .register_reset_cmd        (ev[2]),
        .watchdog_expired          (ev[3]),
        .indicator_function_select (fsel),
        .charge_voltage_trim       (trim),
        .trickle_current_select    (trickle),
        .input_limit_offset        (offs),
        .indicator_out             (ind_out),
        .indicator_oe              (ind_oe)
    );

    cts_host u_host (
        .clk      (clk),
        .sda_line (sda_w),
        .scl      (scl),
        .sda_low  (host_low)
    );

    always #10 clk = ~clk;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ev_pulse(input logic [3:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 4'h0;
    endtask

    // 64 clocks span whole blink periods of both blink modes
    task automatic count_oe(output int n);
        n = 0;
        repeat (4) @(negedge clk);
        repeat (64) begin
            @(negedge clk);
            if (ind_oe === 1'b1) n++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ev = 4'h0;
        fsel = 2'b01;
        num_errors = 0;
        samples_checked = 0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check({trim, 1'b0, trickle, ind_oe, ind_out, offs}, 8'h00);
        check({6'h00, sda_out, sda_oe}, 8'h00);
        u_host.rd(TUNING_CTRL_ADDR, rv);
        check(rv, TUNING_CTRL_RESET);
        u_host.rd(DETECT_STATUS_ADDR, rv);
        check(rv, 8'h00);
        for (k = 0; k < 4; k++) begin
            wv = {k[1:0], 1'b1, k[0], 2'b00, k[1:0]};
            u_host.wr(TUNING_CTRL_ADDR, wv);
            check({6'h00, trim}, {6'h00, k[1:0]});
            check({7'h00, trickle}, {7'h00, k[0]});
            check({6'h00, offs}, {6'h00, k[1:0]});
            u_host.rd(TUNING_CTRL_ADDR, rv);
            check(rv, wv);
        end
        u_host.wr(DETECT_STATUS_ADDR, 8'hFF);
        u_host.rd(DETECT_STATUS_ADDR, rv);
        check(rv, 8'h00);
        ev_pulse(4'b0010);
        u_host.rd(DETECT_STATUS_ADDR, rv);
        check(rv, 8'h80);
        ev_pulse(4'b0001);
        u_host.rd(DETECT_STATUS_ADDR, rv);
        check(rv, 8'h00);
        ev_pulse(4'b0011);
        u_host.rd(DETECT_STATUS_ADDR, rv);
        check(rv, 8'h80);
        for (k = 0; k < 4; k++) begin
            u_host.wr(TUNING_CTRL_ADDR, {4'h0, k[1:0], 2'b00});
            count_oe(hi);
            check(8'(hi), 8'(ind_exp[k]));
        end
        u_host.wr(TUNING_CTRL_ADDR, {4'h0, IND_ON, 2'b00});
        for (k = 0; k < 4; k++) begin
            if (k != 1) begin
                @(negedge clk);
                fsel = k[1:0];
                count_oe(hi);
                check(8'(hi), 8'h00);
            end
        end
        @(negedge clk);
        fsel = 2'b01;
        u_host.wr(TUNING_CTRL_ADDR, 8'hFF);
        ev_pulse(4'b1000);
        check({6'h00, offs}, 8'h03);
        u_host.rd(TUNING_CTRL_ADDR, rv);
        check(rv, 8'h03);
        ev_pulse(4'b0100);
        u_host.rd(TUNING_CTRL_ADDR, rv);
        check(rv, 8'h00);
        u_host.wr(TUNING_CTRL_ADDR, 8'hFF);
        ev_pulse(4'b1100);
        u_host.rd(TUNING_CTRL_ADDR, rv);
        check(rv, 8'h00);
        u_host.wr(TUNING_CTRL_ADDR, 8'hFF);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check({trim, 1'b0, trickle, ind_oe, ind_out, offs}, 8'h00);
        u_host.rd(TUNING_CTRL_ADDR, rv);
        check(rv, TUNING_CTRL_RESET);
        u_host.rd(DETECT_STATUS_ADDR, rv);
        check(rv, 8'h00);
        wrap_up();
    end
endmodule
